// ===== hdl/boot_control_register.sv
// boot control register: loaded from program memory on reset exit, then an AXI4-Lite slave
// assumes program memory answers each byte read with one prog_rvalid pulse, at any latency
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`include "boot_ctrl_defines.svh"
module boot_control_register (
    // clock and resets
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic por_n,
    // register bus
    input wire boot_ctrl_pkg::axi_req_t axi_req,
    output boot_ctrl_pkg::axi_rsp_t axi_rsp,
    // program memory read port
    output logic prog_rd,
    output logic [7:0] prog_addr,
    input wire logic prog_rvalid,
    input wire logic [7:0] prog_rdata,
    // device state and test pins
    input wire logic debug_mode,
    input wire logic active_mode,
    input wire logic cpu_slow,
    input wire logic test_pin,
    input wire logic second_test_pin,
    // write requests
    input wire logic emu_wr_req,
    input wire logic flash_prog_req,
    // internal memory access
    input wire logic mem_access,
    input wire logic mem_chip,
    input wire logic mem_oe,
    input wire logic mem_we,
    input wire logic [3:0] mem_byte_en,
    input wire logic mem_clk_int,
    // outputs
    output boot_ctrl_pkg::cfg_out_t cfg,
    output boot_ctrl_pkg::mem_pins_t mem_pins,
    output logic reset_output_pin_n
);
    // ****************************************
    // helpers
    // ****************************************
    // width flag overrides three bits and the toggle on load and on every write
    function automatic logic [31:0] fix_ctrl(input logic [31:0] v);
        logic [31:0] r;
        r = v;
        if (v[`BC_WIDTH_FLAG]) begin
            r[`BC_PROG_WIDTH] = 1'b1;
            r[`BC_TIMER_HALT] = 1'b1;
            r[`BC_RST_LEN] = 1'b1;
            r[`BC_TEST_TOG] = 1'b0;
        end
        return r;
    endfunction

    function automatic boot_ctrl_pkg::map_region_t map_of(input logic [31:0] v);
        boot_ctrl_pkg::map_region_t m;
        if (v[`BC_MAP_HI]) begin
            m = boot_ctrl_pkg::MAP_FUNC_ROM;
        end else if (v[`BC_MAP_LO]) begin
            m = boot_ctrl_pkg::MAP_ROM;
        end else begin
            m = boot_ctrl_pkg::MAP_RAM;
        end
        return m;
    endfunction

    // ****************************************
    // state
    // ****************************************
    boot_ctrl_pkg::core_state_t s_r;
    boot_ctrl_pkg::core_state_t s_nxt;
    logic load_done;
    logic run;
    logic cs0_act;
    logic cs1_act;
    logic [31:0] merged;
    logic [31:0] rd_word;
    logic rd_ok;

    assign run = (s_r.st == boot_ctrl_pkg::ST_RUN);

    // byte-lane merge for a control write
    always_comb begin
        merged = s_r.ctrl;
        for (int i = 0; i < 4; i++) begin
            if (s_r.wstrb[i]) begin
                merged[i*8 +: 8] = s_r.wdata[i*8 +: 8];
            end
        end
    end

    // read decode
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        case (axi_req.araddr & `ADDR_WORD_MASK)
            `ADDR_BOOT_CONTROL: rd_word = s_r.ctrl;
            `ADDR_BOOT_STATUS: rd_word = {29'h0000_0000, !reset_output_pin_n, s_r.reject, run};
            default: rd_ok = 1'b0;
        endcase
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_nxt = s_r;
        load_done = 1'b0;
        s_nxt.prog_rd = 1'b0;
        case (s_r.st)
            boot_ctrl_pkg::ST_READ: begin
                s_nxt.prog_rd = 1'b1;
                s_nxt.prog_addr = `BOOT_BASE + {6'h00, s_r.idx};
                s_nxt.st = boot_ctrl_pkg::ST_WAIT;
            end
            boot_ctrl_pkg::ST_WAIT: begin
                if (prog_rvalid) begin
                    s_nxt.ctrl[s_r.idx*8 +: 8] = prog_rdata;
                    if (s_r.idx == 2'h1 && prog_rdata[`BC_WIDTH_FLAG - 8]) begin
                        // 16-bit memory has no upper half to fetch
                        s_nxt.ctrl[31:16] = `UPPER_INIT;
                        load_done = 1'b1;
                    end else if (s_r.idx == `BOOT_LAST_IDX) begin
                        load_done = 1'b1;
                    end else begin
                        s_nxt.idx = s_r.idx + 2'h1;
                        s_nxt.st = boot_ctrl_pkg::ST_READ;
                    end
                    if (load_done) begin
                        s_nxt.ctrl = fix_ctrl(s_nxt.ctrl);
                        s_nxt.st = boot_ctrl_pkg::ST_RUN;
                    end
                end
            end
            boot_ctrl_pkg::ST_RUN: begin
                // write address and data may come in either order
                if (axi_req.awvalid && axi_rsp.awready) begin
                    s_nxt.aw_got = 1'b1;
                    s_nxt.awaddr = axi_req.awaddr;
                end
                if (axi_req.wvalid && axi_rsp.wready) begin
                    s_nxt.w_got = 1'b1;
                    s_nxt.wdata = axi_req.wdata;
                    s_nxt.wstrb = axi_req.wstrb;
                end
                if (s_r.aw_got && s_r.w_got) begin
                    s_nxt.aw_got = 1'b0;
                    s_nxt.w_got = 1'b0;
                    s_nxt.bvalid = 1'b1;
                    s_nxt.bresp = 2'b00;
                    case (s_r.awaddr & `ADDR_WORD_MASK)
                        // endian bit is taken as written; software keeps it static
                        `ADDR_BOOT_CONTROL: s_nxt.ctrl = fix_ctrl(merged);
                        `ADDR_BOOT_STATUS: begin
                            if (s_r.wstrb[0] && s_r.wdata[1]) begin
                                s_nxt.reject = 1'b0;
                            end
                        end
                        default: s_nxt.bresp = 2'b10;
                    endcase
                end
                if (s_r.bvalid && axi_req.bready) begin
                    s_nxt.bvalid = 1'b0;
                end
                if (axi_req.arvalid && axi_rsp.arready) begin
                    s_nxt.rvalid = 1'b1;
                    s_nxt.rdata = rd_word;
                    s_nxt.rresp = rd_ok ? 2'b00 : 2'b10;
                end else if (s_r.rvalid && axi_req.rready) begin
                    s_nxt.rvalid = 1'b0;
                end
            end
            default: s_nxt.st = boot_ctrl_pkg::ST_READ;
        endcase

        // sticky reject: a new refusal beats a clear in the same cycle
        if ((emu_wr_req || flash_prog_req) && !s_r.ctrl[`BC_WR_UNLOCK]) begin
            s_nxt.reject = 1'b1;
        end

        // ****************************************
        // configuration outputs
        // ****************************************
        // registered on the base clock, so halting lands on a one-period boundary
        s_nxt.cfg.timers_halt = s_r.ctrl[`BC_TIMER_HALT] && debug_mode;
        s_nxt.cfg.port_mode = (s_r.ctrl[`BC_MFM_HI:`BC_MFM_LO] == 2'h3)
            || (s_r.ctrl[`BC_TEST_TOG] && active_mode && second_test_pin);
        s_nxt.cfg.jtag_active = s_r.ctrl[`BC_JTAG] && second_test_pin;
        s_nxt.cfg.program_access_16 = s_r.ctrl[`BC_PROG_WIDTH];
        s_nxt.cfg.cpu_enable = s_r.ctrl[`BC_CPU];
        s_nxt.cfg.little_endian = s_r.ctrl[`BC_ENDIAN];
        s_nxt.cfg.internal_ram_sel = s_r.ctrl[`BC_RAM];
        s_nxt.cfg.internal_program_rom = s_r.ctrl[`BC_PROG_ROM];
        s_nxt.cfg.internal_function_rom = s_r.ctrl[`BC_FUNC_ROM];
        s_nxt.cfg.trace_full = s_r.ctrl[`BC_TRACE_FULL];
        s_nxt.cfg.trace_macrocell_sel = s_r.ctrl[`BC_TRACE_MC];
        s_nxt.cfg.emu_wr_grant = emu_wr_req && s_r.ctrl[`BC_WR_UNLOCK];
        s_nxt.cfg.flash_prog_grant = flash_prog_req && s_r.ctrl[`BC_WR_UNLOCK];
        s_nxt.cfg.map_region = map_of(s_r.ctrl);

        // ****************************************
        // memory bus pins
        // ****************************************
        s_nxt.slow_cnt = mem_access ? s_r.slow_cnt + 7'h01 : 7'h00;
        if (s_r.ctrl[`BC_FLAG_TWO]) begin
            cs0_act = mem_access && !mem_chip;
            cs1_act = mem_access && mem_chip;
        end else begin
            cs0_act = mem_access && (mem_oe || mem_we);
            cs1_act = 1'b0;
        end
        // full-cycle selects unless the flash power-saving mode trims select zero while cpu_slow is set
        if (s_r.ctrl[`BC_FLAG_ONE] && cpu_slow) begin
            cs0_act = cs0_act && (s_r.slow_cnt == 7'h00);
        end
        s_nxt.mem.chip_select_zero_n = !cs0_act;
        s_nxt.mem.output_enable_n = !(mem_access && mem_oe);
        s_nxt.mem.write_enable_n = !(mem_access && mem_we && s_r.ctrl[`BC_WR_UNLOCK]);
        s_nxt.mem.latch_transparent = !s_r.ctrl[`BC_ASYNC];
        if (s_r.ctrl[`BC_FLAG_ONE]) begin
            s_nxt.mem.chip_select_one_n = 1'b0;
            s_nxt.mem.memory_clock_out = 1'b0;
            s_nxt.mem.byte_write_strobes_n = 4'h0;
            s_nxt.mem.weak_pull_low = 1'b1;
        end else begin
            s_nxt.mem.chip_select_one_n = !cs1_act;
            s_nxt.mem.memory_clock_out = mem_clk_int;
            s_nxt.mem.byte_write_strobes_n = ~((mem_access && mem_we) ? mem_byte_en : 4'h0);
            s_nxt.mem.weak_pull_low = 1'b0;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn || !por_n) begin
            s_r <= '0;
            s_r.st <= boot_ctrl_pkg::ST_READ;
            s_r.ctrl <= `BOOT_CONTROL_RST;
            s_r.prog_addr <= `BOOT_BASE;
            s_r.mem.chip_select_zero_n <= 1'b1;
            s_r.mem.chip_select_one_n <= 1'b1;
            s_r.mem.output_enable_n <= 1'b1;
            s_r.mem.write_enable_n <= 1'b1;
            s_r.mem.byte_write_strobes_n <= 4'hf;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************
    // reset output pulse
    // ****************************************
    reset_pulse_gen u_pulse (
        .aclk(aclk),
        .aresetn(aresetn),
        .por_n(por_n),
        .test_pin(test_pin),
        .start(load_done),
        .short_sel(s_nxt.ctrl[`BC_RST_LEN]),
        .reset_output_pin_n(reset_output_pin_n)
    );

    // ****************************************
    // outputs
    // ****************************************
    assign prog_rd = s_r.prog_rd;
    assign prog_addr = s_r.prog_addr;
    assign cfg = s_r.cfg;
    assign mem_pins = s_r.mem;
    assign axi_rsp.awready = run && !s_r.aw_got && !s_r.bvalid;
    assign axi_rsp.wready = run && !s_r.w_got && !s_r.bvalid;
    assign axi_rsp.bvalid = s_r.bvalid;
    assign axi_rsp.bresp = s_r.bresp;
    assign axi_rsp.arready = run && !s_r.rvalid;
    assign axi_rsp.rvalid = s_r.rvalid;
    assign axi_rsp.rdata = s_r.rdata;
    assign axi_rsp.rresp = s_r.rresp;

    // ****************************************
    // checks
    // ****************************************
    AST_LOAD_ADDR: assert property (@(posedge aclk) disable iff (!aresetn)
        prog_rd |-> prog_addr >= 8'h20 && prog_addr <= 8'h23 && !run)
        else $error("boot byte read outside 0x20..0x23");
    AST_UPPER_INIT: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(run) && s_r.ctrl[`BC_WIDTH_FLAG] |-> s_r.ctrl[31:16] == 16'hfffb)
        else $error("upper half not initialised with width flag set");
    AST_TIMER_HALT: assert property (@(posedge aclk) disable iff (!aresetn)
        debug_mode && s_r.ctrl[`BC_TIMER_HALT] |=> cfg.timers_halt)
        else $error("timers not halted in debug");
    AST_WR_REJECT: assert property (@(posedge aclk) disable iff (!aresetn)
        emu_wr_req && !s_r.ctrl[`BC_WR_UNLOCK] |=> !cfg.emu_wr_grant && s_r.reject)
        else $error("locked emulation write not refused");
    AST_WIDTH_FORCE: assert property (@(posedge aclk) disable iff (!aresetn)
        run && s_r.ctrl[`BC_WIDTH_FLAG] |-> s_r.ctrl[`BC_PROG_WIDTH] && s_r.ctrl[`BC_TIMER_HALT]
            && s_r.ctrl[`BC_RST_LEN] && !s_r.ctrl[`BC_TEST_TOG])
        else $error("width flag overrides not applied");
    AST_JTAG_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg.jtag_active |-> $past(s_r.ctrl[`BC_JTAG]) && $past(second_test_pin))
        else $error("jtag active without bit and pin");
    AST_FLAG_ONE_PINS: assert property (@(posedge aclk) disable iff (!aresetn)
        s_r.ctrl[`BC_FLAG_ONE] |=> !mem_pins.memory_clock_out && mem_pins.byte_write_strobes_n == 4'h0
            && mem_pins.weak_pull_low)
        else $error("power-saving pins not pulled low");
    AST_SLOW_SELECT: assert property (@(posedge aclk) disable iff (!aresetn)
        s_r.ctrl[`BC_FLAG_ONE] && cpu_slow && s_r.slow_cnt != 7'h00 |=> mem_pins.chip_select_zero_n)
        else $error("select zero active outside its slow slot");

    AST_TWO_CHIPS: assert property (@(posedge aclk) disable iff (!aresetn)
        s_r.ctrl[`BC_FLAG_TWO] && !s_r.ctrl[`BC_FLAG_ONE] && mem_access && mem_chip |=> !mem_pins.chip_select_one_n)
        else $error("select one idle in two-chip mode");

    AST_ASYNC_LATCH: assert property (@(posedge aclk) disable iff (!aresetn)
        s_r.ctrl[`BC_ASYNC] |=> !mem_pins.latch_transparent)
        else $error("latches transparent in async mode");

    AST_CPU_ENABLE: assert property (@(posedge aclk) disable iff (!aresetn)
        s_r.ctrl[`BC_CPU] |=> cfg.cpu_enable)
        else $error("processor not enabled");
endmodule // boot_control_register

// ===== hdl/boot_ctrl_defines.svh
// offsets, field positions, reset values and timing counts of the boot control block
// assumes a 40 MHz aclk that also serves as the crystal and base clock
`ifndef BOOT_CTRL_DEFINES_SVH
`define BOOT_CTRL_DEFINES_SVH
// ****************************************
// register map
// ****************************************
`define ADDR_BOOT_CONTROL 32'h0000_0000
`define ADDR_BOOT_STATUS 32'h0000_0004
`define ADDR_WORD_MASK 32'hffff_fffc
// ****************************************
// boot_control fields
// ****************************************
`define BC_TIMER_HALT 31
`define BC_RST_LEN 30
`define BC_TEST_TOG 18
`define BC_WR_UNLOCK 17
`define BC_PROG_WIDTH 16
`define BC_FLAG_TWO 15
`define BC_TRACE_FULL 14
`define BC_TRACE_MC 13
`define BC_FLAG_ONE 12
`define BC_WIDTH_FLAG 11
`define BC_ASYNC 10
`define BC_MFM_HI 9
`define BC_MFM_LO 8
`define BC_JTAG 7
`define BC_ENDIAN 6
`define BC_MAP_HI 5
`define BC_FUNC_ROM 4
`define BC_PROG_ROM 3
`define BC_RAM 2
`define BC_CPU 1
`define BC_MAP_LO 0
// ****************************************
// load source and reset values
// ****************************************
`define BOOT_BASE 8'h20
`define BOOT_LAST_IDX 2'h3
`define UPPER_INIT 16'hfffb
`define BOOT_CONTROL_RST 32'h0000_0000
// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 25
`define XTAL_PERIOD_NS 25
`define RST_SHORT_PERIODS 8
`define RST_LONG_PERIODS 2048
`define RST_SHORT_CYC ((`RST_SHORT_PERIODS * `XTAL_PERIOD_NS) / `CLK_PERIOD_NS)
`define RST_LONG_CYC ((`RST_LONG_PERIODS * `XTAL_PERIOD_NS) / `CLK_PERIOD_NS)
`define SLOW_DIV_BITS 7
`endif

// ===== hdl/boot_ctrl_pkg.sv
// types shared by the boot control block and its reset pulse generator
// assumes nothing beyond a SystemVerilog compiler
package boot_ctrl_pkg;
    typedef enum logic [2:0] {ST_READ = 3'h1, ST_WAIT = 3'h2, ST_RUN = 3'h4} load_state_t;
    typedef enum logic [1:0] {MAP_RAM = 2'h0, MAP_ROM = 2'h1, MAP_FUNC_ROM = 2'h2} map_region_t;
    typedef struct packed {
        logic awvalid; logic [31:0] awaddr; logic wvalid; logic [31:0] wdata;
        logic [3:0] wstrb; logic bready; logic arvalid; logic [31:0] araddr; logic rready;
    } axi_req_t;
    typedef struct packed {
        logic awready; logic wready; logic bvalid; logic [1:0] bresp;
        logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
    } axi_rsp_t;
    typedef struct packed {
        logic chip_select_zero_n; logic chip_select_one_n; logic output_enable_n;
        logic write_enable_n; logic memory_clock_out; logic [3:0] byte_write_strobes_n;
        logic weak_pull_low; logic latch_transparent;
    } mem_pins_t;
    typedef struct packed {
        logic timers_halt; logic port_mode; logic jtag_active; logic program_access_16;
        logic cpu_enable; logic little_endian; logic internal_ram_sel; logic internal_program_rom;
        logic internal_function_rom; logic trace_full; logic trace_macrocell_sel;
        logic emu_wr_grant; logic flash_prog_grant; map_region_t map_region;
    } cfg_out_t;
    typedef struct packed {
        load_state_t st; logic [1:0] idx; logic [31:0] ctrl; logic prog_rd; logic [7:0] prog_addr;
        logic reject; logic aw_got; logic [31:0] awaddr; logic w_got; logic [31:0] wdata;
        logic [3:0] wstrb; logic bvalid; logic [1:0] bresp; logic rvalid; logic [31:0] rdata;
        logic [1:0] rresp; logic [6:0] slow_cnt; cfg_out_t cfg; mem_pins_t mem;
    } core_state_t;
    typedef struct packed {
        logic [11:0] cnt; logic busy; logic hold; logic first_done; logic out_n;
    } pulse_state_t;
endpackage

// ===== hdl/reset_pulse_gen.sv
// reset output pulse generator: 8 or 2048 crystal periods after an internal reset
// assumes por_n is low only at power-on and aresetn covers every internal reset
`include "boot_ctrl_defines.svh"
module reset_pulse_gen (
    // clock and resets
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic por_n,
    // control
    input wire logic test_pin,
    input wire logic start,
    input wire logic short_sel,
    // pin
    output logic reset_output_pin_n
);
    boot_ctrl_pkg::pulse_state_t s_r;
    boot_ctrl_pkg::pulse_state_t s_nxt;
    logic use_short;

    // test pin low forces every pulse long
    assign use_short = test_pin && (!s_r.first_done || short_sel);

    always_comb begin
        s_nxt = s_r;
        if (start && s_r.hold) begin
            s_nxt.hold = 1'b0;
            s_nxt.busy = 1'b1;
            s_nxt.first_done = 1'b1;
            s_nxt.cnt = use_short ? 12'(`RST_SHORT_CYC - 1) : 12'(`RST_LONG_CYC - 1);
        end else if (s_r.busy) begin
            if (s_r.cnt == 12'h000) begin
                s_nxt.busy = 1'b0;
            end else begin
                s_nxt.cnt = s_r.cnt - 12'h001;
            end
        end
        s_nxt.out_n = !(s_nxt.busy || s_nxt.hold);
    end

    // first_done survives internal resets, only power-on clears it
    always_ff @(posedge aclk) begin
        if (!por_n) begin
            s_r <= '{cnt: 12'h000, busy: 1'b0, hold: 1'b1, first_done: 1'b0, out_n: 1'b0};
        end else if (!aresetn) begin
            s_r.cnt <= 12'h000;
            s_r.busy <= 1'b0;
            s_r.hold <= 1'b1;
            s_r.out_n <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reset_output_pin_n = s_r.out_n;

    AST_SHORT_PULSE: assert property (@(posedge aclk) disable iff (!aresetn)
        start && s_r.hold && use_short |=> s_r.busy [*8] ##1 !s_r.busy)
        else $error("short reset pulse is not 8 cycles");
    AST_TEST_LOW_LONG: assert property (@(posedge aclk) disable iff (!aresetn)
        start && s_r.hold && !test_pin |=> s_r.cnt == 12'h7ff && s_r.busy)
        else $error("reset pulse not long with test pin low");
endmodule // reset_pulse_gen

// ===== verification/prog_mem_model.sv
// program memory model answering the boot loader one byte per read
// assumes prog_rd is a one-cycle pulse and prog_addr stays within 0x20..0x23
module prog_mem_model (
    // clock
    input wire logic aclk,
    // read port
    input wire logic prog_rd,
    input wire logic [7:0] prog_addr,
    output logic prog_rvalid,
    output logic [7:0] prog_rdata,
    // contents and answer delay
    input wire logic [31:0] image,
    input wire logic [3:0] lat
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt = 4'h0;
    logic [7:0] byte_r = 8'h00;
    logic [1:0] sel = 2'h0;
    initial prog_rvalid = 1'b0;
    // outside an answer the lines show the inverse, so a stale byte never passes
    assign prog_rdata = prog_rvalid ? byte_r : ~byte_r;
    always @(posedge aclk) begin
        prog_rvalid <= 1'b0;
        if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h1) begin
                prog_rvalid <= 1'b1;
                byte_r <= image[sel*8 +: 8];
            end
        end else if (prog_rd) begin
            cnt <= lat;
            sel <= prog_addr[1:0];
        end
    end
endmodule // prog_mem_model

// ===== verification/testbench.sv
// self-checking bench for the boot control register and its loader
// assumes prog_mem_model as program memory and a 40 MHz aclk
`include "boot_ctrl_defines.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // wiring
    // ****************************************
    logic aclk = 1'b0, aresetn = 1'b0, por_n = 1'b0, debug_mode = 1'b0, active_mode = 1'b0, cpu_slow = 1'b0;
    logic test_pin = 1'b0, second_test_pin = 1'b0, emu_wr_req = 1'b0, flash_prog_req = 1'b0, mem_access = 1'b0;
    logic mem_chip = 1'b0, mem_oe = 1'b0, mem_we = 1'b0, mem_clk_int = 1'b0, prog_rd, prog_rvalid, reset_output_pin_n;
    logic [3:0] mem_byte_en = 4'h0, lat = 4'h1;
    logic [7:0] prog_addr, prog_rdata;
    logic [31:0] image = 32'h0, d;
    logic [1:0] r;
    int n_fail = 0, check_count = 0;
    boot_ctrl_pkg::axi_req_t axi_req = '0;
    boot_ctrl_pkg::axi_rsp_t axi_rsp;
    boot_ctrl_pkg::cfg_out_t cfg;
    boot_ctrl_pkg::mem_pins_t mem_pins;
    boot_control_register DUT (.aclk, .aresetn, .por_n, .axi_req, .axi_rsp, .prog_rd, .prog_addr, .prog_rvalid,
        .prog_rdata, .debug_mode, .active_mode, .cpu_slow, .test_pin, .second_test_pin, .emu_wr_req, .flash_prog_req,
        .mem_access, .mem_chip, .mem_oe, .mem_we, .mem_byte_en, .mem_clk_int, .cfg, .mem_pins, .reset_output_pin_n);
    prog_mem_model prog_mem (.aclk, .prog_rd, .prog_addr, .prog_rvalid, .prog_rdata, .image, .lat);
    initial forever #12.5 aclk = ~aclk;
    // ****************************************
    // bus and check tasks
    // ****************************************
    task automatic chk(input bit ok, input string m);
        check_count++;
        if (!ok) begin
            n_fail++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr <= a;
        axi_req.wvalid <= 1'b1;
        axi_req.wdata <= v;
        axi_req.wstrb <= 4'hf;
        axi_req.bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
            if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
        end while (!axi_rsp.bvalid);
        rs = axi_rsp.bresp;
        axi_req.bready <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr <= a;
        axi_req.rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
        end while (!axi_rsp.rvalid);
        v = axi_rsp.rdata;
        rs = axi_rsp.rresp;
        axi_req.rready <= 1'b0;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic boot(input logic [31:0] img, input logic por, tp, input logic [3:0] lt, input int len, nb);
        int n, m, k;
        @(posedge aclk);
        image <= img;
        lat <= lt;
        test_pin <= tp;
        por_n <= ~por;
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        por_n <= 1'b1;
        aresetn <= 1'b1;
        n = 0;
        m = 0;
        k = 0;
        while (reset_output_pin_n !== 1'b1) begin
            @(posedge aclk);
            #1;
            n += prog_rd;
            k += (m == nb);
            m += prog_rvalid;
        end
        chk(n == nb, "byte reads");
        chk(k >= len && k <= len + 2, "pulse length");
        rd(`ADDR_BOOT_CONTROL, d, r);
        chk(d === (img[11] ? {16'hfffb, img[15:0]} : img), "loaded value");
    endtask
    task automatic t_regs;
        rd(`ADDR_BOOT_STATUS, d, r);
        chk(d[0] === 1'b1 && r === 2'b00, "loaded flag");
        wr(`ADDR_BOOT_CONTROL, 32'h0004_6858, r);
        rd(`ADDR_BOOT_CONTROL, d, r);
        chk(d === 32'hc001_6858, "forced bits");
        chk(cfg.trace_full && cfg.trace_macrocell_sel && cfg.internal_function_rom && cfg.internal_program_rom, "rom");
        wr(32'h0000_0008, 32'h0000_0001, r);
        chk(r === 2'b10, "unmapped write");
        rd(32'h0000_0008, d, r);
        chk(r === 2'b10 && d === 32'h0, "unmapped read");
    endtask
    task automatic t_cfg;
        wr(`ADDR_BOOT_CONTROL, 32'h8006_00c0, r);
        for (int v = 0; v < 2; v++) begin
            @(posedge aclk);
            debug_mode <= v[0];
            second_test_pin <= v[0];
            active_mode <= 1'b1;
            emu_wr_req <= 1'b1;
            @(posedge aclk);
            #1;
            chk(cfg.timers_halt === v[0], "timer halt");
            chk(cfg.jtag_active === v[0], "jtag");
            chk(cfg.port_mode === v[0], "port mode");
            chk(cfg.emu_wr_grant === 1'b1, "write grant");
        end
        wr(`ADDR_BOOT_CONTROL, 32'h0000_00c0, r);
        @(posedge aclk);
        flash_prog_req <= 1'b1;
        @(posedge aclk);
        #1;
        chk(cfg.emu_wr_grant === 1'b0 && cfg.flash_prog_grant === 1'b0, "locked");
        rd(`ADDR_BOOT_STATUS, d, r);
        chk(d[1] === 1'b1, "reject flag");
        emu_wr_req <= 1'b0;
        flash_prog_req <= 1'b0;
    endtask
    task automatic t_mem;
        int n;
        wr(`ADDR_BOOT_CONTROL, 32'h0000_8040, r);
        @(posedge aclk);
        mem_access <= 1'b1;
        mem_chip <= 1'b1;
        mem_oe <= 1'b1;
        @(posedge aclk);
        #1;
        chk(mem_pins.chip_select_one_n === 1'b0 && mem_pins.chip_select_zero_n === 1'b1, "two chips");
        chk(mem_pins.latch_transparent === 1'b1, "sync latches");
        @(posedge aclk);
        mem_chip <= 1'b0;
        repeat (3) begin
            @(posedge aclk);
            #1;
            chk(mem_pins.chip_select_zero_n === 1'b0, "full cycle");
        end
        wr(`ADDR_BOOT_CONTROL, 32'h0002_1440, r);
        @(posedge aclk);
        mem_we <= 1'b1;
        mem_byte_en <= 4'hf;
        mem_clk_int <= 1'b1;
        @(posedge aclk);
        #1;
        chk(mem_pins.weak_pull_low === 1'b1 && mem_pins.memory_clock_out === 1'b0, "pulled low");
        chk(mem_pins.byte_write_strobes_n === 4'h0 && mem_pins.chip_select_one_n === 1'b0, "strobes");
        chk(mem_pins.latch_transparent === 1'b0, "async latches");
        chk(mem_pins.write_enable_n === 1'b0 && mem_pins.output_enable_n === 1'b0, "enables");
        @(posedge aclk);
        cpu_slow <= 1'b1;
        mem_access <= 1'b0;
        n = 0;
        for (int i = 0; i < 512; i++) begin
            @(posedge aclk);
            mem_access <= 1'b1;
            #1;
            n += (mem_pins.chip_select_zero_n === 1'b0);
        end
        chk(n == 4, "slow select");
    endtask
    initial begin
        boot(32'h8001_00c3, 1'b1, 1'b1, 4'h1, `RST_SHORT_CYC, 4);
        chk(cfg.cpu_enable === 1'b1 && cfg.little_endian === 1'b1, "cpu endian");
        chk(cfg.map_region === boot_ctrl_pkg::MAP_ROM && cfg.program_access_16 === 1'b1, "map width");
        boot(32'h8001_00c3, 1'b0, 1'b1, 4'h3, `RST_LONG_CYC, 4);
        boot(32'h4000_0824, 1'b0, 1'b1, 4'h2, `RST_SHORT_CYC, 2);
        chk(cfg.map_region === boot_ctrl_pkg::MAP_FUNC_ROM && cfg.internal_ram_sel === 1'b1, "map ram");
        chk(cfg.cpu_enable === 1'b0, "cpu off");
        boot(32'h4000_0824, 1'b0, 1'b0, 4'h1, `RST_LONG_CYC, 2);
        t_regs();
        t_cfg();
        t_mem();
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        give_verdict();
    end
endmodule // testbench
